//--- ssc_top.sv
// Spindle speed command selection and limiting, Wishbone register access
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none
module ssc_top
  import ssc_pkg::*;
#(
  parameter int ADC_W = 12
) (
  input  wire logic             clk_i,                 // 40 MHz clock
  input  wire logic             rst_i,                 // Sync reset, high
  input  wire logic             ce_i,                  // Clock enable
  input  wire logic             cyc_i,                 // Wishbone cycle
  input  wire logic             stb_i,                 // Wishbone strobe
  input  wire logic             we_i,                  // Wishbone write
  input  wire logic [7:0]       adr_i,                 // Byte address
  input  wire logic [3:0]       sel_i,                 // Byte selects
  input  wire logic [31:0]      dat_i,                 // Write data
  output logic      [31:0]      dat_o,                 // Read data
  output logic                  ack_o,                 // Wishbone ack
  input  wire logic             speed_count_pulse_in,  // Count pulse
  input  wire logic             speed_up_down_in,      // 1 = up
  input  wire logic             speed_point_select_lo, // Select 0
  input  wire logic             speed_point_select_hi, // Select 1
  input  wire logic [ADC_W-1:0] speed_voltage_pos,     // Sampled VR+
  input  wire logic [ADC_W-1:0] speed_voltage_neg,     // Sampled VR-
  input  wire logic             ext_start_i,           // Rotate command
  input  wire logic             ext_dir_i,             // 1 = reverse
  input  wire logic             air_ok_i,              // Cooling air present
  input  wire logic             panel_up_i,            // Panel increase
  input  wire logic             panel_down_i,          // Panel decrease
  output logic      [16:0]      speed_cmd_o,           // Speed setpoint rpm
  output logic                  run_o,                 // Motor run command
  output logic                  reverse_o,             // Reverse direction
  output logic                  speed_reached_out      // Speed achieved
);
  initial begin
    if (ADC_W < 2 || ADC_W > 16) $error("ssc_top: ADC_W out of range");
  end

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [16:0] sat_add(input logic [16:0] a,
                                          input logic [16:0] b,
                                          input logic [16:0] hi);
    logic [17:0] s;
    s = {1'b0, a} + {1'b0, b};
    sat_add = (s > {1'b0, hi}) ? hi : s[16:0];
  endfunction

  function automatic logic [16:0] clamp_range(input logic [16:0] v);
    if (v < SPD_MIN)      clamp_range = SPD_MIN;
    else if (v > SPD_TOP) clamp_range = SPD_TOP;
    else                  clamp_range = v;
  endfunction

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [11:0] ctrl, next_ctrl;
  logic [16:0] fix1, next_fix1, fix2, next_fix2;
  logic [16:0] max1, next_max1, max2, next_max2;
  logic [16:0] panel_spd, next_panel_spd;
  logic [16:0] pulse_spd, next_pulse_spd;
  logic [16:0] actual, next_actual;
  logic [6:0]  level, next_level;
  logic        cnt_q, next_cnt_q, up_q, next_up_q, dn_q, next_dn_q;
  logic [31:0] next_dat;
  ssc_bus_t    bus, next_bus;
  logic [16:0] next_cmd;
  logic        next_run, next_rev, next_reached;

  logic        wr, rd_req;
  logic        pt_we;
  logic [16:0] pt_rdat;
  logic [1:0]  pt_sel;
  logic [7:0]  pt_off;
  logic [16:0] lim, spd_lim, req;
  logic        motor2;
  ssc_src_t    src;
  logic [ADC_W:0]  vdiff;
  logic [16:0]     vspd;
  logic [33:0]     prod_act, prod_cmd;

  // Ack is registered: one wait state per access
  // A request is not taken again while its ack stands
  assign wr     = cyc_i && stb_i && we_i && (bus == SSC_BUS_IDLE);
  assign rd_req = cyc_i && stb_i && (bus == SSC_BUS_IDLE);
  assign pt_we  = wr && sel_i[0] && adr_i >= SSC_ADR_PT0 &&
                  adr_i < SSC_ADR_PANEL;
  assign motor2 = ctrl[CTRL_MOTOR2];
  assign src    = ssc_src_t'(ctrl[CTRL_MODE_LO +: 2]);
  assign pt_sel = {speed_point_select_hi, speed_point_select_lo};
  // Preset index from the offset; raw address bits would rotate U1..U4
  assign pt_off = adr_i - SSC_ADR_PT0;

  ssc_point_mem #(
    .WIDTH (17),
    .DEPTH (4)
  ) u_pts (
    .clk_i  (clk_i),
    .ce_i   (ce_i),
    .we_i   (pt_we),
    .wadr_i (pt_off[3:2]),
    .wdat_i (clamp_range(dat_i[16:0])),
    .radr_i (pt_sel),
    .rdat_o (pt_rdat)
  );

  ssc_limit u_lim (
    .req_i     (req),
    .fix_en_i  (motor2 ? ctrl[CTRL_FIX2] : ctrl[CTRL_FIX1]),
    .fix_i     (motor2 ? fix2 : fix1),
    .max_en_i  (motor2 ? ctrl[CTRL_MAX2] : ctrl[CTRL_MAX1]),
    .max_i     (motor2 ? max2 : max1),
    .air_cap_i (!ctrl[CTRL_AIR_OFF] && !air_ok_i),
    .lim_o     (lim),
    .spd_o     (spd_lim)
  );

  // ----------------------------------------------------------------------
  // Setpoint source selection
  // ----------------------------------------------------------------------
  always_comb begin
    // Negative differential reads as zero speed before range clamp
    vdiff = {1'b0, speed_voltage_pos} - {1'b0, speed_voltage_neg};
    if (vdiff[ADC_W])
      vspd = 17'd0;
    else
      vspd = 17'((34'(vdiff[ADC_W-1:0]) * 34'(SPD_TOP)) >> ADC_W);
    if (!ctrl[CTRL_AUTO] || ctrl[CTRL_PANEL]) begin
      req = panel_spd;
    end else begin
      case (src)
        SSC_SRC_ANALOG: req = clamp_range(vspd);
        SSC_SRC_PULSE:  req = pulse_spd;
        SSC_SRC_POINT:  req = pt_rdat;
        // Unused mode code falls back to the panel
        default:        req = panel_spd;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    logic [16:0] step;
    step           = ctrl[CTRL_PULSE_1K] ? STEP_LARGE : STEP_SMALL;
    next_ctrl      = ctrl;
    next_fix1      = fix1;
    next_fix2      = fix2;
    next_max1      = max1;
    next_max2      = max2;
    next_panel_spd = panel_spd;
    next_pulse_spd = pulse_spd;
    next_actual    = actual;
    next_level     = level;
    next_cnt_q     = speed_count_pulse_in;
    next_up_q      = panel_up_i;
    next_dn_q      = panel_down_i;
    next_bus       = SSC_BUS_IDLE;
    next_dat       = dat_o;
    if (rd_req) begin
      next_bus = SSC_BUS_ACK;
      case (adr_i)
        SSC_ADR_CTRL:   next_dat = {20'h0, ctrl};
        SSC_ADR_FIX1:   next_dat = {15'h0, fix1};
        SSC_ADR_FIX2:   next_dat = {15'h0, fix2};
        SSC_ADR_MAX1:   next_dat = {15'h0, max1};
        SSC_ADR_MAX2:   next_dat = {15'h0, max2};
        SSC_ADR_PANEL:  next_dat = {15'h0, panel_spd};
        SSC_ADR_ACTUAL: next_dat = {15'h0, actual};
        SSC_ADR_STATUS: next_dat = {12'h0, speed_reached_out, reverse_o,
                                    run_o, speed_cmd_o};
        SSC_ADR_LEVEL:  next_dat = {25'h0, level};
        default:        next_dat = 32'h0000_0000;
      endcase
    end
    if (wr && sel_i[0]) begin
      case (adr_i)
        SSC_ADR_CTRL:   next_ctrl = dat_i[11:0];
        SSC_ADR_FIX1:   next_fix1 = clamp_range(dat_i[16:0]);
        SSC_ADR_FIX2:   next_fix2 = clamp_range(dat_i[16:0]);
        SSC_ADR_MAX1:   next_max1 = clamp_range(dat_i[16:0]);
        SSC_ADR_MAX2:   next_max2 = clamp_range(dat_i[16:0]);
        SSC_ADR_PANEL:  next_panel_spd = clamp_range(dat_i[16:0]);
        SSC_ADR_ACTUAL: next_actual = dat_i[16:0];
        SSC_ADR_LEVEL: begin
          if (dat_i[6:0] >= LEVEL_MIN && dat_i[6:0] <= LEVEL_MAX)
            next_level = dat_i[6:0];
        end
        default: ;
      endcase
    end
    // Limitation: panel and pulse share one step size
    // Panel buttons step on their press edge
    if (panel_up_i && !up_q)
      next_panel_spd = sat_add(panel_spd, step, SPD_TOP);
    else if (panel_down_i && !dn_q)
      next_panel_spd = (panel_spd > SPD_MIN + step) ?
                       panel_spd - step : SPD_MIN;
    // Count on the rising edge; direction sampled with the pulse
    if (speed_count_pulse_in && !cnt_q) begin
      if (speed_up_down_in)
        next_pulse_spd = sat_add(pulse_spd, step, lim);
      else if (pulse_spd > SPD_MIN + step)
        next_pulse_spd = pulse_spd - step;
      else
        next_pulse_spd = SPD_MIN;
    end
    if (next_pulse_spd > lim) next_pulse_spd = lim;
  end

  // ----------------------------------------------------------------------
  // Outputs: run, direction, reached
  // ----------------------------------------------------------------------
  always_comb begin
    next_cmd = spd_lim;
    // Ignored start inputs leave run and direction as they were
    if (ctrl[CTRL_AUTO] && ctrl[CTRL_EXTSTART]) begin
      next_run = ext_start_i;
      next_rev = ext_dir_i;
    end else begin
      next_run = run_o;
      next_rev = reverse_o;
    end
    // Products avoid a divider in the level compare
    prod_act = 34'(actual) * 34'd100;
    prod_cmd = 34'(spd_lim) * 34'(level);
    next_reached = next_run && (prod_act >= prod_cmd);
  end

  // ----------------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------------
  // Reset acts whatever the clock enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl              <= CTRL_RESET;
      fix1              <= SPD_RESET;
      fix2              <= SPD_RESET;
      max1              <= SPD_TOP;
      max2              <= SPD_TOP;
      panel_spd         <= SPD_RESET;
      pulse_spd         <= SPD_RESET;
      actual            <= 17'h0_0000;
      level             <= LEVEL_RESET;
      cnt_q             <= 1'b0;
      up_q              <= 1'b0;
      dn_q              <= 1'b0;
      bus               <= SSC_BUS_IDLE;
      dat_o             <= 32'h0000_0000;
      ack_o             <= 1'b0;
      speed_cmd_o       <= 17'h0_0000;
      run_o             <= 1'b0;
      reverse_o         <= 1'b0;
      speed_reached_out <= 1'b0;
    end else if (ce_i) begin
      ctrl              <= next_ctrl;
      fix1              <= next_fix1;
      fix2              <= next_fix2;
      max1              <= next_max1;
      max2              <= next_max2;
      panel_spd         <= next_panel_spd;
      pulse_spd         <= next_pulse_spd;
      actual            <= next_actual;
      level             <= next_level;
      cnt_q             <= next_cnt_q;
      up_q              <= next_up_q;
      dn_q              <= next_dn_q;
      bus               <= next_bus;
      dat_o             <= next_dat;
      ack_o             <= (next_bus == SSC_BUS_ACK);
      speed_cmd_o       <= next_cmd;
      run_o             <= next_run;
      reverse_o         <= next_rev;
      speed_reached_out <= next_reached;
    end
  end
endmodule
`default_nettype wire

//--- ssc_pkg.sv
// Package: constants and types for the spindle speed command select block
package ssc_pkg;
  // ----------------------------------------------------------------------
  // Register map (word offsets as byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] SSC_ADR_CTRL    = 8'h00;
  localparam logic [7:0] SSC_ADR_FIX1    = 8'h04;
  localparam logic [7:0] SSC_ADR_FIX2    = 8'h08;
  localparam logic [7:0] SSC_ADR_MAX1    = 8'h0C;
  localparam logic [7:0] SSC_ADR_MAX2    = 8'h10;
  localparam logic [7:0] SSC_ADR_PT0     = 8'h14;
  localparam logic [7:0] SSC_ADR_PANEL   = 8'h24;
  localparam logic [7:0] SSC_ADR_ACTUAL  = 8'h28;
  localparam logic [7:0] SSC_ADR_STATUS  = 8'h2C;
  localparam logic [7:0] SSC_ADR_LEVEL   = 8'h30;
  // ----------------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------------
  localparam int CTRL_AUTO     = 0;
  localparam int CTRL_PANEL    = 1;
  localparam int CTRL_FIX1     = 2;
  localparam int CTRL_FIX2     = 3;
  localparam int CTRL_MAX1     = 4;
  localparam int CTRL_MAX2     = 5;
  localparam int CTRL_MODE_LO  = 6;
  localparam int CTRL_EXTSTART = 8;
  localparam int CTRL_AIR_OFF  = 9;
  localparam int CTRL_PULSE_1K = 10;
  localparam int CTRL_MOTOR2   = 11;
  localparam logic [11:0] CTRL_RESET = 12'h000;
  // ----------------------------------------------------------------------
  // Speed figures in rpm, reached levels in percent
  // ----------------------------------------------------------------------
  localparam logic [16:0] SPD_MIN       = 17'd1000;
  localparam logic [16:0] SPD_TOP       = 17'd80000;
  localparam logic [16:0] SPD_NO_AIR    = 17'd30000;
  localparam logic [16:0] STEP_SMALL    = 17'd200;
  localparam logic [16:0] STEP_LARGE    = 17'd1000;
  localparam logic [16:0] SPD_RESET     = 17'd1000;
  localparam logic [6:0]  LEVEL_RESET   = 7'd90;
  localparam logic [6:0]  LEVEL_MIN     = 7'd50;
  localparam logic [6:0]  LEVEL_MAX     = 7'd100;

  typedef enum logic [1:0] {
    SSC_SRC_ANALOG = 2'b00,
    SSC_SRC_PULSE  = 2'b01,
    SSC_SRC_POINT  = 2'b10
  } ssc_src_t;

  typedef enum logic [0:0] {
    SSC_BUS_IDLE = 1'b0,
    SSC_BUS_ACK  = 1'b1
  } ssc_bus_t;
endpackage

//--- ssc_point_mem.sv
// Four-entry speed-point preset store with registered read
`timescale 1ns/100ps
`default_nettype none
module ssc_point_mem
  import ssc_pkg::*;
#(
  parameter int WIDTH = 17,
  parameter int DEPTH = 4
) (
  input  wire logic                     clk_i,  // System clock
  input  wire logic                     ce_i,   // Clock enable
  input  wire logic                     we_i,   // Write strobe
  input  wire logic [$clog2(DEPTH)-1:0] wadr_i, // Write index
  input  wire logic [WIDTH-1:0]         wdat_i, // Write data
  input  wire logic [$clog2(DEPTH)-1:0] radr_i, // Read index
  output logic      [WIDTH-1:0]         rdat_o  // Registered read data
);
  initial begin
    if (DEPTH != 4 || WIDTH < 17) $error("ssc_point_mem: bad parameters");
  end

  logic [WIDTH-1:0] mem [DEPTH];

  // No reset: software loads presets before use
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      if (we_i) mem[wadr_i] <= wdat_i;
      rdat_o <= mem[radr_i];
    end
  end
endmodule
`default_nettype wire

//--- ssc_limit.sv
// Speed limiting stage: maximum, air cap, fixed speed
`timescale 1ns/100ps
`default_nettype none
module ssc_limit
  import ssc_pkg::*;
(
  input  wire logic [16:0] req_i,      // Requested setpoint
  input  wire logic        fix_en_i,   // Fixed speed enabled
  input  wire logic [16:0] fix_i,      // Fixed speed value
  input  wire logic        max_en_i,   // Maximum enabled
  input  wire logic [16:0] max_i,      // Maximum value
  input  wire logic        air_cap_i,  // Cap for missing air
  output logic      [16:0] lim_o,      // Effective ceiling
  output logic      [16:0] spd_o       // Limited setpoint
);
  logic [16:0] base;

  always_comb begin
    lim_o = max_en_i ? max_i : SPD_TOP;
    if (air_cap_i && lim_o > SPD_NO_AIR) lim_o = SPD_NO_AIR;
    base  = fix_en_i ? fix_i : req_i;
    spd_o = (base > lim_o) ? lim_o : base;
  end
endmodule
`default_nettype wire

//--- ssc_chk.sv
// Port checker for the speed command select block
`timescale 1ns/100ps
`default_nettype none
module ssc_chk
  import ssc_pkg::*;
(
  input  wire logic        clk_i,       // System clock
  input  wire logic        rst_i,       // Sync reset
  input  wire logic        ce_i,        // Clock enable
  input  wire logic        cyc_i,       // Bus cycle
  input  wire logic        stb_i,       // Bus strobe
  input  wire logic        we_i,        // Bus write
  input  wire logic [7:0]  adr_i,       // Bus address
  input  wire logic [3:0]  sel_i,       // Byte selects
  input  wire logic [31:0] dat_i,       // Write data
  input  wire logic        ack_o,       // Bus ack
  input  wire logic        ext_start_i, // Rotate command
  input  wire logic        ext_dir_i,   // Direction
  input  wire logic        air_ok_i,    // Air present
  input  wire logic [16:0] speed_cmd_o, // Setpoint
  input  wire logic        run_o,       // Run
  input  wire logic        reverse_o    // Reverse
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------
  // Shadow of control and limit registers
  // ----------------------------------------
  logic [11:0] ctl, next_ctl;
  logic [16:0] spd [4];
  logic [16:0] next_spd [4];
  logic [16:0] wv, cl0, cl, fx, expv;
  logic        tk, m2, fx_on, ext_on;
  always_comb begin
    // Snooped at the taking edge so the shadow moves with the design
    tk = cyc_i && stb_i && we_i && !ack_o && ce_i && sel_i[0];
    wv = (dat_i[16:0] < SPD_MIN) ? SPD_MIN : dat_i[16:0];
    wv = (wv > SPD_TOP) ? SPD_TOP : wv;
    next_ctl = ctl;
    next_spd = spd;
    if (tk && adr_i == SSC_ADR_CTRL) next_ctl = dat_i[11:0];
    if (tk && adr_i >= SSC_ADR_FIX1 && adr_i <= SSC_ADR_MAX2)
      next_spd[adr_i[4:2] - 3'h1] = wv;
    m2 = ctl[CTRL_MOTOR2];
    fx_on = m2 ? ctl[CTRL_FIX2] : ctl[CTRL_FIX1];
    fx = spd[{1'b0, m2}];
    cl0 = (m2 ? ctl[CTRL_MAX2] : ctl[CTRL_MAX1]) ? spd[{1'b1, m2}] : SPD_TOP;
    cl = (!ctl[CTRL_AIR_OFF] && !air_ok_i && cl0 > SPD_NO_AIR) ?
         SPD_NO_AIR : cl0;
    expv = (fx > cl) ? cl : fx;
    ext_on = ctl[CTRL_AUTO] && ctl[CTRL_EXTSTART];
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl <= CTRL_RESET;
      spd <= '{SPD_RESET, SPD_RESET, SPD_TOP, SPD_TOP};
    end else if (ce_i) begin
      ctl <= next_ctl;
      spd <= next_spd;
    end
  end
  chk_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  chk_ack_cause: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i))
    else $error("ack without a request");
  chk_speed_range: assert property (!$past(rst_i) && !$past(rst_i, 2)
    |-> speed_cmd_o >= SPD_MIN && speed_cmd_o <= SPD_TOP)
    else $error("setpoint outside the speed range");
  chk_fix_hold: assert property ((fx_on && $stable(expv))[*3]
    |-> speed_cmd_o == expv) else $error("fixed speed not held");
  chk_ceiling_cap: assert property ($stable(cl)[*3]
    |-> speed_cmd_o <= cl) else $error("setpoint above ceiling");
  chk_dir_follow: assert property (ext_on |=>
    reverse_o == $past(ext_dir_i))
    else $error("direction not following input");
  chk_run_follow: assert property (ext_on |=>
    run_o == $past(ext_start_i))
    else $error("run not following start");
  chk_ext_ignore: assert property (!ext_on |=>
    $stable(run_o) && $stable(reverse_o))
    else $error("run or direction moved while ignored");
  cov_fix: cover property (fx_on && speed_cmd_o == expv);
  cov_air: cover property (!air_ok_i && speed_cmd_o == SPD_NO_AIR);
  cov_rev: cover property (ext_on && run_o && reverse_o);
endmodule
`default_nettype wire

//--- ssc_mc_model.sv
// Machine controller model driving the external command pins
`timescale 1ns/100ps
`default_nettype none
module ssc_mc_model (
  input  wire logic        clk_i,   // System clock
  output logic             pulse_o, // Count pulse
  output logic             up_o,    // 1 = count up
  output logic [1:0]       sel_o,   // Point select {hi, lo}
  output logic [11:0]      vp_o,    // Positive voltage sample
  output logic [11:0]      vn_o,    // Negative voltage sample
  output logic             start_o, // Rotate command
  output logic             dir_o    // 1 = reverse
);
  initial {pulse_o, up_o, sel_o, vp_o, vn_o, start_o, dir_o} = '0;
  // Callers enter at a rising edge; levels hold until the next call
  task automatic set_in(input logic [11:0] p, input logic [11:0] n,
                        input logic [1:0] s, input logic st, input logic d);
    {vp_o, vn_o, sel_o, start_o, dir_o} <= {p, n, s, st, d};
  endtask
  // Direction settles a full cycle before the first pulse edge
  task automatic count(input logic up, input int n);
    up_o <= up;
    @(posedge clk_i);
    repeat (n) begin
      pulse_o <= 1'b1;
      repeat (2) @(posedge clk_i);
      pulse_o <= 1'b0;
      repeat (2) @(posedge clk_i);
    end
  endtask
endmodule
`default_nettype wire

//--- tb_top.sv
// Self-checking bench for the speed command select block
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import ssc_pkg::*;
  ;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0;
  logic        we = 1'b0, air_ok = 1'b1, ack_o, run_o, reverse_o, reached;
  logic        pulse, up, start, dir, ce = 1'b1;
  logic [1:0]  psel, pnl = 2'b00;
  logic [3:0]  sel = 4'hF;
  logic [7:0]  adr = 8'h00;
  logic [11:0] vp, vn;
  logic [16:0] speed_cmd_o, e;
  logic [16:0] pt [4];
  logic [31:0] dat = 32'h0, dat_o, rd;
  int          n_errors = 0, checks = 0, cycles = 0;
  logic [7:0]  radr [6] = '{8'h00, 8'h04, 8'h0C, 8'h30, 8'h14, 8'h3C};
  logic [31:0] rexp [6] = '{32'h0, 32'h3E8, 32'h13880, 32'h5A, 32'h0, 32'h0};
  logic        pu [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
  int          pn [5] = '{1, 3, 1, 2, 80};
  logic [31:0] pe [5] = '{32'h3E8, 32'h640, 32'h578, 32'hD48, 32'h13880};
  logic [11:0] vt [9] = '{12'hFFF, 12'h0, 12'hFFF, 12'hFFF, 12'hFFF,
                          12'hFFF, 12'hFFF, 12'hFFF, 12'hFFF};
  logic [31:0] ct [9] = '{32'h205, 32'h205, 32'h215, 32'h211, 32'hA29,
                          32'hA21, 32'h001, 32'h001, 32'h201};
  logic [31:0] et [9] = '{32'hC350, 32'hC350, 32'h0, 32'h0, 32'h2EE0,
                          32'hEA60, 32'h7530, 32'h1386C, 32'h1386C};
  always #12.5 clk_i = ~clk_i;
  ssc_top #(.ADC_W(12)) u_ssc_top (.clk_i(clk_i), .rst_i(rst_i),
    .ce_i(ce), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
    .speed_count_pulse_in(pulse), .speed_up_down_in(up),
    .speed_point_select_lo(psel[0]), .speed_point_select_hi(psel[1]),
    .speed_voltage_pos(vp), .speed_voltage_neg(vn), .ext_start_i(start),
    .ext_dir_i(dir), .air_ok_i(air_ok), .panel_up_i(pnl[0]),
    .panel_down_i(pnl[1]), .speed_cmd_o(speed_cmd_o), .run_o(run_o),
    .reverse_o(reverse_o), .speed_reached_out(reached));
  ssc_mc_model u_ssc_mc_model (.clk_i(clk_i), .pulse_o(pulse), .up_o(up),
    .sel_o(psel), .vp_o(vp), .vn_o(vn), .start_o(start), .dir_o(dir));
  // ----------------------------------------
  // Bus, compare and expectation helpers
  // ----------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s: got %0h expected %0h", $time, what, got, exp);
    end
  endtask
  // Entered at a rising edge; leaves one idle cycle before returning
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 100);
    rd = dat_o;
    {cyc, stb, we} <= 3'b000;
    if (n >= 100) chk(32'h0, 32'h1, "bus ack missing");
    @(posedge clk_i);
  endtask
  function automatic logic [16:0] lim(input int v);
    return (v < 1000) ? SPD_MIN : (v > 80000) ? SPD_TOP : 17'(v);
  endfunction
  function automatic logic [16:0] ana(input int p, input int n);
    return lim((p > n) ? ((p - n) * 80000) >>> 12 : 0);
  endfunction
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      $display("[FAIL] %0t run did not finish", $time);
      conclude();
    end
  end
  initial begin
    void'($urandom(23152));
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int i = 0; i < 6; i++) begin
      wb(1'b0, radr[i], 32'h0);
      chk(rd, rexp[i], "reset value");
    end
    chk(32'(speed_cmd_o), 32'h3E8, "manual speed");
    $display("test reset done");
    wb(1'b1, SSC_ADR_CTRL, 32'h201);
    for (int i = 0; i < 6; i++) begin
      u_ssc_mc_model.set_in((i == 0) ? 12'h0 : 12'($urandom),
                            (i == 1) ? 12'hFFF : 12'($urandom % 512),
                            2'b00, 1'b0, 1'b0);
      repeat (4) @(posedge clk_i);
      chk(32'(speed_cmd_o), 32'(ana(vp, vn)), "analog speed");
    end
    e = lim($urandom % 90000);
    wb(1'b1, SSC_ADR_PANEL, 32'(e));
    wb(1'b1, SSC_ADR_CTRL, 32'h203);
    repeat (4) @(posedge clk_i);
    chk(32'(speed_cmd_o), 32'(e), "panel source");
    sel <= 4'h0;
    wb(1'b1, SSC_ADR_PANEL, 32'h1388);
    sel <= 4'hF;
    wb(1'b0, SSC_ADR_PANEL, 32'h0);
    chk(rd, 32'(e), "masked write");
    for (int i = 0; i < 2; i++) begin
      pnl <= 2'(i + 1);
      repeat (2) @(posedge clk_i);
      pnl <= 2'b00;
      repeat (3) @(posedge clk_i);
      e = lim((i == 0) ? e + 200 : e - 200);
      chk(32'(speed_cmd_o), 32'(e), "panel button");
    end
    $display("test analog and panel done");
    for (int i = 0; i < 4; i++) begin
      pt[i] = (i == 0) ? SPD_TOP : (i == 3) ? SPD_MIN :
              lim(1000 + $urandom % 79001);
      wb(1'b1, 8'(SSC_ADR_PT0 + 4 * i), 32'(pt[i]));
    end
    wb(1'b1, SSC_ADR_CTRL, 32'h281);
    for (int i = 3; i >= 0; i--) begin
      u_ssc_mc_model.set_in(12'h0, 12'h0, 2'(i), 1'b0, 1'b0);
      repeat (4) @(posedge clk_i);
      chk(32'(speed_cmd_o), 32'(pt[i]), "speed point");
    end
    $display("test speed points done");
    wb(1'b1, SSC_ADR_CTRL, 32'h241);
    for (int i = 0; i < 5; i++) begin
      if (i == 3) wb(1'b1, SSC_ADR_CTRL, 32'h641);
      u_ssc_mc_model.count(pu[i], pn[i]);
      repeat (2) @(posedge clk_i);
      chk(32'(speed_cmd_o), pe[i], "pulse setpoint");
    end
    // A pulse while the enable is low must leave the setpoint alone
    ce <= 1'b0;
    u_ssc_mc_model.count(1'b0, 1);
    ce <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk(32'(speed_cmd_o), 32'h13880, "frozen by enable");
    $display("test pulses done");
    e = lim(20000 + $urandom % 20000);
    et[2] = 32'(e);
    et[3] = 32'(e);
    wb(1'b1, SSC_ADR_FIX1, 32'hC350);
    wb(1'b1, SSC_ADR_MAX1, 32'(e));
    wb(1'b1, SSC_ADR_FIX2, 32'h2EE0);
    wb(1'b1, SSC_ADR_MAX2, 32'hEA60);
    for (int i = 0; i < 9; i++) begin
      air_ok <= !(i == 6 || i == 8);
      u_ssc_mc_model.set_in(vt[i], 12'h0, 2'b00, 1'b0, 1'b0);
      wb(1'b1, SSC_ADR_CTRL, ct[i]);
      repeat (4) @(posedge clk_i);
      chk(32'(speed_cmd_o), et[i], "speed limit");
    end
    $display("test limits done");
    wb(1'b1, SSC_ADR_PANEL, 32'h2710);
    wb(1'b1, SSC_ADR_CTRL, 32'h303);
    u_ssc_mc_model.set_in(12'h0, 12'h0, 2'b00, 1'b1, 1'b1);
    repeat (4) @(posedge clk_i);
    chk(32'({run_o, reverse_o}), 32'h3, "start reverse");
    u_ssc_mc_model.set_in(12'h0, 12'h0, 2'b00, 1'b1, 1'b0);
    repeat (4) @(posedge clk_i);
    chk(32'({run_o, reverse_o}), 32'h2, "start forward");
    wb(1'b1, SSC_ADR_CTRL, 32'h203);
    u_ssc_mc_model.set_in(12'h0, 12'h0, 2'b00, 1'b0, 1'b1);
    repeat (4) @(posedge clk_i);
    chk(32'({run_o, reverse_o}), 32'h2, "start ignored");
    wb(1'b0, SSC_ADR_STATUS, 32'h0);
    chk(rd, 32'h22710, "status word");
    wb(1'b1, SSC_ADR_ACTUAL, 32'h2328);
    chk(32'(reached), 32'h1, "reached at level");
    wb(1'b1, SSC_ADR_ACTUAL, 32'h2327);
    chk(32'(reached), 32'h0, "below level");
    wb(1'b1, SSC_ADR_LEVEL, 32'h28);
    wb(1'b0, SSC_ADR_LEVEL, 32'h0);
    chk(rd, 32'h5A, "level out of range");
    wb(1'b1, SSC_ADR_LEVEL, 32'h32);
    chk(32'(reached), 32'h1, "lower level");
    $display("test start and reached done");
    conclude();
  end
endmodule
bind ssc_top ssc_chk u_ssc_chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
  .dat_i(dat_i), .ack_o(ack_o), .ext_start_i(ext_start_i),
  .ext_dir_i(ext_dir_i), .air_ok_i(air_ok_i), .speed_cmd_o(speed_cmd_o),
  .run_o(run_o), .reverse_o(reverse_o));
`default_nettype wire
